// >>> include/mmu_status_pkg.sv
package mmu_status_pkg;

  // ****************************************************************
  // Register selects for the move instruction
  // ****************************************************************
  localparam logic [2:0] SEL_CPU_ROOT = 3'h0;
  localparam logic [2:0] SEL_SUP_ROOT = 3'h1;
  localparam logic [2:0] SEL_CONTROL = 3'h2;
  localparam logic [2:0] SEL_WINDOW_ZERO = 3'h3;
  localparam logic [2:0] SEL_WINDOW_ONE = 3'h4;
  localparam logic [2:0] SEL_FAULT_STATUS = 3'h5;

  // ****************************************************************
  // Control, window and root pointer fields
  // ****************************************************************
  localparam int CTL_ENABLE_BIT = 31;
  localparam int CTL_PAGE_LSB = 20;
  localparam int CTL_SHIFT_LSB = 16;
  localparam int CTL_IDX_A_LSB = 12;
  localparam int CTL_IDX_B_LSB = 8;
  localparam int CTL_IDX_C_LSB = 4;
  localparam int CTL_IDX_D_LSB = 0;
  localparam logic [6:0] CTL_ADDR_BITS = 7'h20;
  localparam int WINDOW_ENABLE_BIT = 15;
  localparam int ROOT_DT_LSB = 32;
  localparam logic [1:0] ROOT_DT_INVALID = 2'h0;

  // ****************************************************************
  // Fault status fields and reset values
  // ****************************************************************
  localparam int FS_BERR_BIT = 15;
  localparam int FS_LIMIT_BIT = 14;
  localparam int FS_SUPER_BIT = 13;
  localparam int FS_WPROT_BIT = 11;
  localparam int FS_INVALID_BIT = 10;
  localparam int FS_MOD_BIT = 9;
  localparam int FS_TRANSP_BIT = 6;
  localparam int FS_LEVEL_LSB = 0;
  localparam logic [2:0] FS_LEVEL_MAX = 3'h7;
  localparam logic [15:0] FS_RESET = 16'h0000;
  localparam logic [31:0] REG32_RESET = 32'h0000_0000;
  localparam logic [63:0] REG64_RESET = 64'h0000_0000_0000_0000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic hit;
    logic berr;
    logic wprot;
    logic modified;
  } cache_look_s;

  typedef struct packed {
    logic berr;
    logic limit;
    logic super_only;
    logic wprot;
    logic bad_type;
    logic page;
    logic modified;
  } walk_desc_s;

endpackage

// >>> rtl/ctl_consistency.sv
`timescale 1ns/1ps
// Checks a control word: index sum plus page size and shift, and page-size code
module ctl_consistency (
  input wire logic [31:0] ctl_i,
  output logic sum_ok_o,
  output logic page_ok_o
);

  logic [6:0] sum;
  logic [3:0] idx_a;
  logic [3:0] idx_b;
  logic [3:0] idx_c;
  logic [3:0] idx_d;

  assign idx_a = ctl_i[mmu_status_pkg::CTL_IDX_A_LSB +: 4];
  assign idx_b = ctl_i[mmu_status_pkg::CTL_IDX_B_LSB +: 4];
  assign idx_c = ctl_i[mmu_status_pkg::CTL_IDX_C_LSB +: 4];
  assign idx_d = ctl_i[mmu_status_pkg::CTL_IDX_D_LSB +: 4];

  // Index fields summed up to the first zero field
  // sum of fields
  always_comb begin
    sum = {3'h0, ctl_i[mmu_status_pkg::CTL_PAGE_LSB +: 4]}
        + {3'h0, ctl_i[mmu_status_pkg::CTL_SHIFT_LSB +: 4]}
        + {3'h0, idx_a};
    if (idx_a != 4'h0) begin
      sum = sum + {3'h0, idx_b};
      if (idx_b != 4'h0) begin
        sum = sum + {3'h0, idx_c};
        if (idx_c != 4'h0) begin
          sum = sum + {3'h0, idx_d};
        end
      end
    end
  end

  assign sum_ok_o = (sum == mmu_status_pkg::CTL_ADDR_BITS);
  assign page_ok_o = ctl_i[mmu_status_pkg::CTL_PAGE_LSB + 3];

endmodule

// >>> rtl/mmu_status_config.sv
`timescale 1ns/1ps
// Fault status capture and translation register load checking
module mmu_status_config #(
  parameter logic [7:0] CFG_VECTOR = 8'h40  // Vector number, arbitrary default
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic MOVE_REQ_I,
  input wire logic MOVE_WRITE_I,
  input wire logic [2:0] MOVE_SEL_I,
  input wire logic MOVE_FD_I,
  input wire logic [63:0] MOVE_WDATA_I,
  output logic MOVE_ACK_O,
  output logic [63:0] MOVE_RDATA_O,
  input wire logic PROBE_REQ_I,
  input wire logic [2:0] PROBE_LEVEL_I,
  input wire logic [2:0] PROBE_FC_I,
  input wire mmu_status_pkg::cache_look_s CACHE_LOOK_I,
  input wire logic WINDOW_MATCH_I,
  input wire logic WALK_DESC_VALID_I,
  input wire mmu_status_pkg::walk_desc_s WALK_DESC_I,
  input wire logic WALK_DONE_I,
  output logic PROBE_BUSY_O,
  output logic PROBE_DONE_O,
  output logic [15:0] FAULT_STATUS_O,
  output logic FLUSH_ALL_O,
  output logic CFG_EXC_O,
  output logic [7:0] CFG_VECTOR_O,
  output logic [31:0] CONTROL_O,
  output logic [31:0] WINDOW_ZERO_O,
  output logic [31:0] WINDOW_ONE_O,
  output logic [63:0] CPU_ROOT_O,
  output logic [63:0] SUP_ROOT_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic {ST_IDLE, ST_WALK} probe_state_e;

  probe_state_e state_r;
  logic [31:0] control_r;
  logic [31:0] window_zero_r;
  logic [31:0] window_one_r;
  logic [63:0] cpu_root_r;
  logic [63:0] sup_root_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [63:0] rdata_r;
  logic ack_r;
  logic flush_r;
  logic cfg_exc_r;
  logic done_r;
  logic fc_top_r;
  logic acc_berr_r;
  logic acc_limit_r;
  logic acc_super_r;
  logic acc_wprot_r;
  logic acc_bad_r;
  logic acc_mod_r;
  logic [2:0] acc_level_r;
  logic acc_berr_nxt;
  logic acc_limit_nxt;
  logic acc_super_nxt;
  logic acc_wprot_nxt;
  logic acc_bad_nxt;
  logic acc_mod_nxt;
  logic [2:0] acc_level_nxt;
  logic wr_req;
  logic ctl_load;
  logic root_load;
  logic trans_load;
  logic sum_ok;
  logic page_ok;
  logic ctl_bad;
  logic root_bad;
  logic cache_probe;
  logic walk_finish;
  logic status_load;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  assign wr_req = MOVE_REQ_I && MOVE_WRITE_I;
  assign ctl_load = wr_req && (MOVE_SEL_I == mmu_status_pkg::SEL_CONTROL);
  assign root_load = wr_req && ((MOVE_SEL_I == mmu_status_pkg::SEL_CPU_ROOT)
                             || (MOVE_SEL_I == mmu_status_pkg::SEL_SUP_ROOT));
  assign trans_load = wr_req && (MOVE_SEL_I <= mmu_status_pkg::SEL_WINDOW_ONE);
  assign status_load = wr_req && (MOVE_SEL_I == mmu_status_pkg::SEL_FAULT_STATUS);
  assign cache_probe = PROBE_REQ_I && (state_r == ST_IDLE) && (PROBE_LEVEL_I == 3'h0);
  assign walk_finish = (state_r == ST_WALK) && WALK_DONE_I;

  ctl_consistency u_check (
    .ctl_i(MOVE_WDATA_I[31:0]),
    .sum_ok_o(sum_ok),
    .page_ok_o(page_ok)
  );

  // Enabled word must add up; page code is checked on every load
  // enabled sum check
  assign ctl_bad = ctl_load && ((MOVE_WDATA_I[mmu_status_pkg::CTL_ENABLE_BIT] && !sum_ok)
                             || !page_ok);
  assign root_bad = root_load
      && (MOVE_WDATA_I[mmu_status_pkg::ROOT_DT_LSB +: 2] == mmu_status_pkg::ROOT_DT_INVALID);

  // ****************************************************************
  // Translation registers
  // ****************************************************************
  // Control word, enable dropped when the word fails its check
  // reset clears the whole word
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      control_r <= mmu_status_pkg::REG32_RESET;
    end else if (ctl_load) begin
      control_r <= MOVE_WDATA_I[31:0];
      if (ctl_bad) begin
        control_r[mmu_status_pkg::CTL_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  // Transparent windows
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      window_zero_r <= mmu_status_pkg::REG32_RESET;
      window_one_r <= mmu_status_pkg::REG32_RESET;
    end else if (wr_req) begin
      if (MOVE_SEL_I == mmu_status_pkg::SEL_WINDOW_ZERO) begin
        window_zero_r <= MOVE_WDATA_I[31:0];
      end
      if (MOVE_SEL_I == mmu_status_pkg::SEL_WINDOW_ONE) begin
        window_one_r <= MOVE_WDATA_I[31:0];
      end
    end
  end

  // Root pointers are stored even when their type is invalid
  // store in the same cycle as exception
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cpu_root_r <= mmu_status_pkg::REG64_RESET;
      sup_root_r <= mmu_status_pkg::REG64_RESET;
    end else if (wr_req) begin
      if (MOVE_SEL_I == mmu_status_pkg::SEL_CPU_ROOT) begin
        cpu_root_r <= MOVE_WDATA_I;
      end
      if (MOVE_SEL_I == mmu_status_pkg::SEL_SUP_ROOT) begin
        sup_root_r <= MOVE_WDATA_I;
      end
    end
  end

  // ****************************************************************
  // Move answer, flush and configuration exception
  // ****************************************************************
  // Read data for the selected register, acknowledge one cycle later
  // read all six
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_r <= mmu_status_pkg::REG64_RESET;
      ack_r <= 1'b0;
    end else begin
      ack_r <= MOVE_REQ_I;
      if (MOVE_REQ_I && !MOVE_WRITE_I) begin
        case (MOVE_SEL_I)
          mmu_status_pkg::SEL_CPU_ROOT: rdata_r <= cpu_root_r;
          mmu_status_pkg::SEL_SUP_ROOT: rdata_r <= sup_root_r;
          mmu_status_pkg::SEL_CONTROL: rdata_r <= {32'h0000_0000, control_r};
          mmu_status_pkg::SEL_WINDOW_ZERO: rdata_r <= {32'h0000_0000, window_zero_r};
          mmu_status_pkg::SEL_WINDOW_ONE: rdata_r <= {32'h0000_0000, window_one_r};
          mmu_status_pkg::SEL_FAULT_STATUS: rdata_r <= {48'h0000_0000_0000, status_r};
          default: rdata_r <= mmu_status_pkg::REG64_RESET;
        endcase
      end
    end
  end

  // Flush pulse and exception pulse, both with the acknowledge
  // optional flush
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flush_r <= 1'b0;
      cfg_exc_r <= 1'b0;
    end else begin
      flush_r <= trans_load && !MOVE_FD_I;
      cfg_exc_r <= ctl_bad || root_bad;
    end
  end

  // ****************************************************************
  // Probe sequencing and walk accumulation
  // ****************************************************************
  // Walk flags gathered per descriptor, the last read included
  // any write protect
  always_comb begin
    acc_berr_nxt = acc_berr_r;
    acc_limit_nxt = acc_limit_r;
    acc_super_nxt = acc_super_r;
    acc_wprot_nxt = acc_wprot_r;
    acc_bad_nxt = acc_bad_r;
    acc_mod_nxt = acc_mod_r;
    acc_level_nxt = acc_level_r;
    if (WALK_DESC_VALID_I && (state_r == ST_WALK)) begin
      acc_berr_nxt = acc_berr_r | WALK_DESC_I.berr;
      acc_limit_nxt = acc_limit_r | WALK_DESC_I.limit;
      acc_super_nxt = acc_super_r | (WALK_DESC_I.super_only && !fc_top_r);
      acc_wprot_nxt = acc_wprot_r | WALK_DESC_I.wprot;
      acc_bad_nxt = acc_bad_r | WALK_DESC_I.bad_type;
      if (WALK_DESC_I.page) begin
        acc_mod_nxt = WALK_DESC_I.modified;
      end
      if (acc_level_r != mmu_status_pkg::FS_LEVEL_MAX) begin
        acc_level_nxt = acc_level_r + 3'h1;
      end
    end
  end

  // Probe state and accumulators
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= ST_IDLE;
      fc_top_r <= 1'b0;
      acc_berr_r <= 1'b0;
      acc_limit_r <= 1'b0;
      acc_super_r <= 1'b0;
      acc_wprot_r <= 1'b0;
      acc_bad_r <= 1'b0;
      acc_mod_r <= 1'b0;
      acc_level_r <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (PROBE_REQ_I && (PROBE_LEVEL_I != 3'h0)) begin
            state_r <= ST_WALK;
            fc_top_r <= PROBE_FC_I[2];
            acc_berr_r <= 1'b0;
            acc_limit_r <= 1'b0;
            acc_super_r <= 1'b0;
            acc_wprot_r <= 1'b0;
            acc_bad_r <= 1'b0;
            acc_mod_r <= 1'b0;
            acc_level_r <= 3'h0;
          end
        end
        ST_WALK: begin
          acc_berr_r <= acc_berr_nxt;
          acc_limit_r <= acc_limit_nxt;
          acc_super_r <= acc_super_nxt;
          acc_wprot_r <= acc_wprot_nxt;
          acc_bad_r <= acc_bad_nxt;
          acc_mod_r <= acc_mod_nxt;
          acc_level_r <= acc_level_nxt;
          if (WALK_DONE_I) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Fault status value
  // ****************************************************************
  // Status word built for a cache probe or a finished walk
  always_comb begin
    status_nxt = mmu_status_pkg::FS_RESET;
    if (cache_probe) begin
      if (WINDOW_MATCH_I) begin
        status_nxt[mmu_status_pkg::FS_TRANSP_BIT] = 1'b1;
      end else begin
        status_nxt[mmu_status_pkg::FS_BERR_BIT] = CACHE_LOOK_I.hit && CACHE_LOOK_I.berr;
        status_nxt[mmu_status_pkg::FS_WPROT_BIT] = CACHE_LOOK_I.wprot;
        status_nxt[mmu_status_pkg::FS_INVALID_BIT] = !CACHE_LOOK_I.hit || CACHE_LOOK_I.berr;
        status_nxt[mmu_status_pkg::FS_MOD_BIT] = CACHE_LOOK_I.modified;
      end
    end else begin
      status_nxt[mmu_status_pkg::FS_BERR_BIT] = acc_berr_nxt;
      status_nxt[mmu_status_pkg::FS_LIMIT_BIT] = acc_limit_nxt;
      status_nxt[mmu_status_pkg::FS_SUPER_BIT] = acc_super_nxt;
      status_nxt[mmu_status_pkg::FS_WPROT_BIT] = acc_wprot_nxt;
      status_nxt[mmu_status_pkg::FS_INVALID_BIT] = acc_bad_nxt || acc_berr_nxt
                                                || acc_limit_nxt;
      status_nxt[mmu_status_pkg::FS_MOD_BIT] = acc_mod_nxt;
      status_nxt[mmu_status_pkg::FS_LEVEL_LSB +: 3] = acc_level_nxt;
    end
  end

  // Status held until a probe finishes or software loads it; probe wins
  // hold status
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      status_r <= mmu_status_pkg::FS_RESET;
      done_r <= 1'b0;
    end else begin
      done_r <= cache_probe || walk_finish;
      if (cache_probe || walk_finish) begin
        status_r <= status_nxt;
      end else if (status_load) begin
        status_r <= MOVE_WDATA_I[15:0];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign MOVE_ACK_O = ack_r;
  assign MOVE_RDATA_O = rdata_r;
  assign PROBE_BUSY_O = (state_r == ST_WALK);
  assign PROBE_DONE_O = done_r;
  assign FAULT_STATUS_O = status_r;
  assign FLUSH_ALL_O = flush_r;
  assign CFG_EXC_O = cfg_exc_r;
  assign CFG_VECTOR_O = CFG_VECTOR;
  assign CONTROL_O = control_r;
  assign WINDOW_ZERO_O = window_zero_r;
  assign WINDOW_ONE_O = window_one_r;
  assign CPU_ROOT_O = cpu_root_r;
  assign SUP_ROOT_O = sup_root_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence seq_flush_load;
    trans_load && !MOVE_FD_I;
  endsequence

  sequence seq_bad_ctl;
    ctl_load && MOVE_WDATA_I[mmu_status_pkg::CTL_ENABLE_BIT] && !sum_ok;
  endsequence

  flush_on_load_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    seq_flush_load |=> FLUSH_ALL_O ##1 !FLUSH_ALL_O || $past(trans_load && !MOVE_FD_I))
    else $error("flush missing after translation load");

  no_flush_fd_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (MOVE_REQ_I && MOVE_FD_I) |=> !FLUSH_ALL_O)
    else $error("flush despite flush-disable");

  ctl_sum_exc_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    seq_bad_ctl |=> CFG_EXC_O && !CONTROL_O[mmu_status_pkg::CTL_ENABLE_BIT]
      && (CONTROL_O[30:0] == $past(MOVE_WDATA_I[30:0])))
    else $error("bad control load not refused");

  page_code_exc_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (ctl_load && !MOVE_WDATA_I[mmu_status_pkg::CTL_PAGE_LSB + 3]) |=> CFG_EXC_O)
    else $error("reserved page code accepted");

  root_type_exc_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (wr_req && (MOVE_SEL_I == mmu_status_pkg::SEL_CPU_ROOT)
      && (MOVE_WDATA_I[33:32] == 2'h0)) |=> CFG_EXC_O && (CPU_ROOT_O == $past(MOVE_WDATA_I)))
    else $error("invalid root not stored or not flagged");

  cache_status_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (cache_probe && !WINDOW_MATCH_I) |=> PROBE_DONE_O
      && (FAULT_STATUS_O[mmu_status_pkg::FS_INVALID_BIT]
          == $past(!CACHE_LOOK_I.hit || CACHE_LOOK_I.berr))
      && !FAULT_STATUS_O[mmu_status_pkg::FS_LIMIT_BIT]
      && (FAULT_STATUS_O[2:0] == 3'h0))
    else $error("cache probe status wrong");

  walk_invalid_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    walk_finish |=> FAULT_STATUS_O[mmu_status_pkg::FS_INVALID_BIT]
      == (FAULT_STATUS_O[mmu_status_pkg::FS_BERR_BIT] || FAULT_STATUS_O[mmu_status_pkg::FS_LIMIT_BIT]
          || $past(acc_bad_nxt)))
    else $error("walk invalid bit wrong");

  walk_levels_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_r == ST_IDLE && PROBE_REQ_I && PROBE_LEVEL_I != 3'h0)
      ##1 !(WALK_DESC_VALID_I || WALK_DONE_I) ##1 (WALK_DESC_VALID_I && WALK_DONE_I)
      |=> (FAULT_STATUS_O[2:0] == 3'h1) && !FAULT_STATUS_O[mmu_status_pkg::FS_TRANSP_BIT])
    else $error("one-table walk not counted");

  status_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (!cache_probe && !walk_finish && !status_load) |=> $stable(FAULT_STATUS_O))
    else $error("fault status changed without cause");

endmodule

// >>> tb/test_mmu_status_config.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_mmu_status_config;
  localparam logic [7:0] VEC = 8'h5A;  // Arbitrary vector number
  logic clk = 0, rst_n = 0, mreq = 0, mwr = 0, mfd = 0, preq = 0, win = 0, dval = 0, wdone = 0;
  logic [2:0] msel = 0, plev = 0, pfc = 0;
  logic [63:0] mwd = 0, rdata, croot, sroot;
  mmu_status_pkg::cache_look_s look = '0;
  mmu_status_pkg::walk_desc_s desc = '0;
  logic ack, flush, exc, busy, pdone;
  logic [15:0] fs;
  logic [7:0] vec;
  logic [31:0] ctl, w0, w1;
  logic [63:0] regs [0:7];
  logic [69:0] mq [$];  // Write, select, flush, exception, data
  logic [31:0] pq [$];  // Compare mask, expected status
  int fails = 0, cmp_count = 0;
  mmu_status_config #(.CFG_VECTOR(VEC)) u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
    .MOVE_REQ_I(mreq), .MOVE_WRITE_I(mwr), .MOVE_SEL_I(msel), .MOVE_FD_I(mfd),
    .MOVE_WDATA_I(mwd), .MOVE_ACK_O(ack), .MOVE_RDATA_O(rdata), .PROBE_REQ_I(preq),
    .PROBE_LEVEL_I(plev), .PROBE_FC_I(pfc), .CACHE_LOOK_I(look), .WINDOW_MATCH_I(win),
    .WALK_DESC_VALID_I(dval), .WALK_DESC_I(desc), .WALK_DONE_I(wdone),
    .PROBE_BUSY_O(busy), .PROBE_DONE_O(pdone), .FAULT_STATUS_O(fs), .FLUSH_ALL_O(flush),
    .CFG_EXC_O(exc), .CFG_VECTOR_O(vec), .CONTROL_O(ctl), .WINDOW_ZERO_O(w0),
    .WINDOW_ONE_O(w1), .CPU_ROOT_O(croot), .SUP_ROOT_O(sroot));
  // Clock at 10 MHz
  initial forever #50 clk = ~clk;
  // Watchdog cuts a hang short
  initial begin
    #2000000;
    fails++;
    report_and_stop();
  end
  // ****************************************
  // Result monitor
  // ****************************************
  always @(negedge clk) begin
    logic [69:0] m;
    logic [31:0] p;
    logic [63:0] got;
    if (ack) begin
      m = mq.pop_front();
      case (m[68:66])
        3'h0: got = croot;
        3'h1: got = sroot;
        3'h2: got = {32'h0, ctl};
        3'h3: got = {32'h0, w0};
        3'h4: got = {32'h0, w1};
        default: got = {48'h0, fs};
      endcase
      if (!m[69]) got = rdata;
      `CHK("move flags", m[65:64], {flush, exc})
      `CHK("move data", m[63:0], got)
    end
    if (pdone) begin
      p = pq.pop_front();
      `CHK("fault status", p[15:0], fs & p[31:16])
    end
  end
  // ****************************************
  // Drivers and expectations
  // ****************************************
  function automatic logic ctl_bad(input logic [31:0] c);
    int sum;
    logic stop;
    sum = c[23:20] + c[19:16];
    stop = 0;
    for (int i = 3; i >= 0; i--) begin
      if (c[i*4+:4] == 0) stop = 1;
      if (!stop) sum += c[i*4+:4];
    end
    return !c[23] || (c[31] && sum != 32);
  endfunction
  task automatic mv(input logic w, input logic [2:0] s, input logic fd, input logic [63:0] d);
    logic bad;
    logic [63:0] v;
    bad = 0;
    v = 0;
    case (s)
      3'h0, 3'h1: begin v = d; bad = d[33:32] == 2'h0; end
      3'h2: begin v = {32'h0, d[31:0]}; bad = ctl_bad(d[31:0]); v[31] = v[31] & !bad; end
      3'h3, 3'h4: v = {32'h0, d[31:0]};
      3'h5: v = {48'h0, d[15:0]};
      default: v = 0;
    endcase
    if (w && s < 6) regs[s] = v;
    if (!w) v = regs[s];
    mq.push_back({w, s, w & !fd & (s < 5), w & bad, v});
    @(posedge clk);
    #1 {mreq, mwr, msel, mfd, mwd} = {1'b1, w, s, fd, d};
    @(posedge clk);
    #1 mreq = 0;
  endtask
  task automatic p0(input logic [3:0] lk, input logic wm);
    logic [15:0] e, m;
    e = 0;
    e[15] = lk[3] & lk[2];
    e[10] = !lk[3] | lk[2];
    e[11] = lk[1];
    e[9] = lk[0];
    m = e[10] ? 16'hF5FF : 16'hFFFF;
    if (wm) begin e = 16'h0040; m = 16'h0040; end
    pq.push_back({m, e & m});
    look = lk;
    @(posedge clk);
    #1 {preq, plev, win} = {1'b1, 3'h0, wm};
    @(posedge clk);
    #1 {preq, win} = 2'b00;
  endtask
  task automatic pw(input int n);
    logic [15:0] e;
    logic pg;
    e = 0;
    pg = 0;
    plev = 3'($urandom_range(7, 1));
    pfc = 3'($urandom);
    @(posedge clk);
    #1 preq = 1;
    @(posedge clk);
    #1 preq = 0;
    `CHK("busy", 1'b1, busy)
    @(posedge clk);
    #1;
    for (int i = 0; i < n; i++) begin
      desc = 7'($urandom);
      {dval, wdone} = {1'b1, i == n - 1};
      e[15] |= desc.berr;
      e[14] |= desc.limit;
      e[13] |= desc.super_only & !pfc[2];
      e[11] |= desc.wprot;
      e[10] |= desc.bad_type;
      if (desc.page) begin pg = 1; e[9] = desc.modified; end
      @(posedge clk);
      #1;
    end
    {dval, wdone} = 2'b00;
    `CHK("idle", 1'b0, busy)
    e[10] |= e[15] | e[14];
    e[2:0] = n > 7 ? 3'h7 : 3'(n);
    e = e & (e[10] ? 16'hD5FF : (pg ? 16'hFFFF : 16'hFDFF));
    pq.push_back({e[10] ? 16'hD5FF : (pg ? 16'hFFFF : 16'hFDFF), e});
  endtask
  task automatic rst();
    #1 rst_n = 0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    for (int i = 0; i < 8; i++) regs[i] = 0;
    `CHK("enables", 3'h0, {ctl[31], w0[15], w1[15]})
    `CHK("no reset flush", 1'b0, flush)
  endtask
  task automatic report_and_stop();
    `CHK("moves left", 0, mq.size())
    `CHK("probes left", 0, pq.size())
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] ct [5] = '{32'h80C0AA00, 32'h80C0AA10, 32'h80C0AA01, 32'h0070AA00, 32'h00F01234};
    void'($urandom(74));
    rst();
    `CHK("vector", VEC, vec)
    for (int i = 0; i < 5; i++) mv(1, 3'h2, i[0], {32'h0, ct[i]});
    mv(1, 3'h0, 0, 64'h0000_0000_1234_5670);
    mv(1, 3'h1, 1, 64'h0000_0002_89AB_CDE0);
    for (int s = 0; s < 6; s++) begin
      mv(1, s[2:0], 1'($urandom), {$urandom, $urandom});
      mv(0, s[2:0], 0, 64'h0);
    end
    mv(0, 3'h6, 0, 64'h0);
    for (int i = 0; i < 32; i++) p0(i[3:0], i[4]);
    p0(4'hB, 0);
    regs[5] = 64'h0A00;
    mv(0, 3'h5, 0, 64'h0);
    for (int k = 0; k < 9; k++) pw(k + 1);
    mv(1, 3'h3, 0, 64'h8000);
    mv(1, 3'h4, 1, 64'hFFFF);
    mv(1, 3'h2, 0, 64'h80C0AA00);
    repeat (2) @(posedge clk);
    rst();
    mv(1, 3'h0, 0, 64'h0000_0001_0000_0000);
    mv(0, 3'h1, 0, 64'h0);
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule
